// >>> hdl/hdp_poll_master.sv
// Half-duplex poll master: list sequencer, link framing, registers
// How it works
// - Poll list in order, wrap forever
// - Priority entries interleaved, polled more often
// - Slave inactive after retries used up
// - Single mode: one message, then advance
// - Multiple mode: repoll until queue empty
// - Timeout bounds wait for reply
// - RTS delays before and after sending
// - Polls generated without user command
// - Queued master message sent inside sequence
// - Two-byte reply ends slave's messages
// - One responsiveness bit per address 0-254
// - Address 255 is broadcast, never listed
`timescale 1ns/1ps
module hdp_poll_master
  import hdp_pkg::*;
#(
  parameter int LIST_N = 16
)(
  input wire logic mclk_in,
  input wire logic reset_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic [31:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [31:0] reg_rdata_out,
  output logic irq_out,
  output logic [7:0] tx_byte_out,
  output logic tx_valid_out,
  input wire logic tx_ready_in,
  input wire logic [7:0] rx_byte_in,
  input wire logic rx_valid_in,
  output logic rts_out,
  output logic [7:0] rx_data_out,
  output logic rx_data_valid_out
);
  localparam int IW = $clog2(LIST_N);
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (reset_in);
  // ----------------------------------------------------------------
  // Tick divider and timers
  // ----------------------------------------------------------------
  logic [7:0] div_r, div_nxt;
  logic tick_r, tick_nxt;
  logic rts_start, tmo_start, rts_done, tmo_done;
  logic [15:0] rts_load;
  hdp_rx_ev_t rx;

  always_comb
  begin
    tick_nxt = (div_r == 8'(TICK_CYC - 1));
    div_nxt = tick_nxt ? 8'h00 : div_r + 8'h01;
  end

  always_ff @(posedge mclk_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      div_r <= 8'h00;
      tick_r <= 1'b0;
    end
    else
    begin
      div_r <= div_nxt;
      tick_r <= tick_nxt;
    end
  end
  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [7:0] ctrl_r, ctrl_nxt, node_sel_r, node_sel_nxt;
  logic [15:0] tmo_r, tmo_nxt, pre_r, pre_nxt, post_r, post_nxt;
  logic [IW:0] nlen_r, nlen_nxt, plen_r, plen_nxt;
  logic msg_pend_r, msg_pend_nxt, msg_clr;
  logic [7:0] msg_dest_r, msg_dest_nxt, msg_data_r, msg_data_nxt;
  logic [3:0] stat_r, stat_nxt, mask_r, mask_nxt, ev;
  logic [31:0] rdata_r, rdata_nxt;
  logic irq_r;
  logic [7:0] nlist [LIST_N];
  logic [7:0] plist [LIST_N];
  logic [254:0] active_r, active_nxt;
  hdp_state_t st_r, st_nxt;
  logic [7:0] cur_r, cur_nxt;
  logic wr_list, list_bc;

  assign wr_list = reg_wr_in && reg_addr_in == REG_LIST_WR;
  assign list_bc = reg_wdata_in[7:0] == ADDR_BCAST;

  always_comb
  begin
    ctrl_nxt = ctrl_r;
    tmo_nxt = tmo_r;
    pre_nxt = pre_r;
    post_nxt = post_r;
    nlen_nxt = nlen_r;
    plen_nxt = plen_r;
    msg_dest_nxt = msg_dest_r;
    msg_data_nxt = msg_data_r;
    node_sel_nxt = node_sel_r;
    mask_nxt = mask_r;
    msg_pend_nxt = msg_pend_r && !msg_clr;
    stat_nxt = stat_r;
    rdata_nxt = 32'h0000_0000;
    if (reg_wr_in)
    begin
      case (reg_addr_in)
        REG_CTRL: ctrl_nxt = reg_wdata_in[7:0];
        REG_TMO: tmo_nxt = reg_wdata_in[15:0];
        REG_RTS_PRE: pre_nxt = reg_wdata_in[15:0];
        REG_RTS_POST: post_nxt = reg_wdata_in[15:0];
        REG_LEN:
        begin
          nlen_nxt = reg_wdata_in[IW:0];
          plen_nxt = reg_wdata_in[LEN_PRIO_LO +: IW+1];
        end
        REG_MSG:
        begin
          msg_dest_nxt = reg_wdata_in[7:0];
          msg_data_nxt = reg_wdata_in[MSG_DATA_LO +: 8];
          msg_pend_nxt = 1'b1;
        end
        REG_NODE: node_sel_nxt = reg_wdata_in[7:0];
        REG_IRQ_STAT: stat_nxt = stat_r & ~reg_wdata_in[3:0];
        REG_IRQ_MASK: mask_nxt = reg_wdata_in[3:0];
        default: ;
      endcase
    end
    stat_nxt = stat_nxt | ev;
    if (reg_rd_in)
    begin
      case (reg_addr_in)
        REG_CTRL: rdata_nxt = {24'h0, ctrl_r};
        REG_TMO: rdata_nxt = {16'h0, tmo_r};
        REG_RTS_PRE: rdata_nxt = {16'h0, pre_r};
        REG_RTS_POST: rdata_nxt = {16'h0, post_r};
        REG_LEN: rdata_nxt = 32'({plen_r, 8'(nlen_r)});
        REG_MSG: rdata_nxt = {31'h0, msg_pend_r};
        REG_NODE: rdata_nxt = {31'h0, node_sel_r != ADDR_BCAST && active_r[node_sel_r]};
        REG_IRQ_STAT: rdata_nxt = {28'h0, stat_r};
        REG_IRQ_MASK: rdata_nxt = {28'h0, mask_r};
        REG_STATUS: rdata_nxt = {18'h0, st_r, cur_r};
        REG_RXDATA: rdata_nxt = {24'h0, rx_data_out};
        default: rdata_nxt = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge mclk_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      ctrl_r <= CTRL_RST;
      tmo_r <= TMO_RST;
      pre_r <= RTS_PRE_RST;
      post_r <= RTS_POST_RST;
      nlen_r <= '0;
      plen_r <= '0;
      msg_pend_r <= 1'b0;
      msg_dest_r <= 8'h00;
      msg_data_r <= 8'h00;
      node_sel_r <= 8'h00;
      stat_r <= 4'h0;
      mask_r <= 4'h0;
      rdata_r <= 32'h0000_0000;
      irq_r <= 1'b0;
    end
    else
    begin
      ctrl_r <= ctrl_nxt;
      tmo_r <= tmo_nxt;
      pre_r <= pre_nxt;
      post_r <= post_nxt;
      nlen_r <= nlen_nxt;
      plen_r <= plen_nxt;
      msg_pend_r <= msg_pend_nxt;
      msg_dest_r <= msg_dest_nxt;
      msg_data_r <= msg_data_nxt;
      node_sel_r <= node_sel_nxt;
      stat_r <= stat_nxt;
      mask_r <= mask_nxt;
      rdata_r <= rdata_nxt;
      irq_r <= |(stat_nxt & mask_nxt);
    end
  end

  // List memories; broadcast address is refused
  always_ff @(posedge mclk_in)
  begin
    if (wr_list && !list_bc && reg_wdata_in[LIST_PRIO])
      plist[reg_wdata_in[LIST_IDX_LO +: IW]] <= reg_wdata_in[7:0];
    else if (wr_list && !list_bc)
      nlist[reg_wdata_in[LIST_IDX_LO +: IW]] <= reg_wdata_in[7:0];
  end

  a_no_bcast_entry: assert property ((st_r == ST_PICK) |=> cur_r != ADDR_BCAST)
    else $error("broadcast address polled");
  // ----------------------------------------------------------------
  // Poll sequencer
  // ----------------------------------------------------------------
  logic [IW-1:0] nidx_r, nidx_nxt, pidx_r, pidx_nxt;
  logic prio_turn_r, prio_turn_nxt, from_prio_r, from_prio_nxt;
  logic kind_msg_r, kind_msg_nxt, adv, use_p;
  logic [3:0] tries_r, tries_nxt;
  logic [2:0] bidx_r, bidx_nxt, blast;
  logic [7:0] tx_byte_nxt;
  logic tx_valid_nxt, rts_nxt;

  function automatic logic [7:0] pkt_byte(input logic m, input logic [2:0] i,
                                          input logic [7:0] a, input logic [7:0] d);
    case (i)
      3'h0: pkt_byte = B_DLE;
      3'h1: pkt_byte = m ? B_STX : B_ENQ;
      3'h2: pkt_byte = a;
      3'h3: pkt_byte = d;
      3'h4: pkt_byte = B_DLE;
      default: pkt_byte = B_ETX;
    endcase
  endfunction

  assign blast = kind_msg_r ? 3'h5 : 3'h2;
  assign use_p = plen_r != '0 && (prio_turn_r || nlen_r == '0);

  always_comb
  begin
    st_nxt = st_r;
    cur_nxt = cur_r;
    nidx_nxt = nidx_r;
    pidx_nxt = pidx_r;
    prio_turn_nxt = prio_turn_r;
    from_prio_nxt = from_prio_r;
    kind_msg_nxt = kind_msg_r;
    tries_nxt = tries_r;
    bidx_nxt = bidx_r;
    tx_byte_nxt = tx_byte_out;
    tx_valid_nxt = tx_valid_out;
    rts_nxt = rts_out;
    active_nxt = active_r;
    rts_start = 1'b0;
    rts_load = pre_r;
    tmo_start = 1'b0;
    msg_clr = 1'b0;
    adv = 1'b0;
    ev = 4'h0;
    case (st_r)
      ST_IDLE: if (ctrl_r[CTRL_EN]) st_nxt = ST_PICK;
      ST_PICK:
      begin
        bidx_nxt = 3'h0;
        tries_nxt = 4'h0;
        rts_start = 1'b1;
        st_nxt = ST_RTSON;
        if (!ctrl_r[CTRL_EN] || (!msg_pend_r && nlen_r == '0 && plen_r == '0))
        begin
          rts_start = 1'b0;
          st_nxt = ST_IDLE;
        end
        else if (msg_pend_r)
        begin
          kind_msg_nxt = 1'b1;
          cur_nxt = msg_dest_r;
        end
        else
        begin
          kind_msg_nxt = 1'b0;
          from_prio_nxt = use_p;
          cur_nxt = use_p ? plist[pidx_r] : nlist[nidx_r];
        end
      end
      ST_RTSON:
      begin
        rts_nxt = 1'b1;
        if (rts_done)
        begin
          st_nxt = ST_SEND;
          bidx_nxt = 3'h0;
          tx_valid_nxt = 1'b1;
          tx_byte_nxt = pkt_byte(kind_msg_r, 3'h0, cur_r, msg_data_r);
        end
      end
      ST_SEND:
        if (tx_valid_out && tx_ready_in)
        begin
          if (bidx_r == blast)
          begin
            tx_valid_nxt = 1'b0;
            rts_start = 1'b1;
            rts_load = post_r;
            st_nxt = ST_RTSOFF;
          end
          else
          begin
            bidx_nxt = bidx_r + 3'h1;
            tx_byte_nxt = pkt_byte(kind_msg_r, bidx_nxt, cur_r, msg_data_r);
          end
        end
      ST_RTSOFF:
        if (rts_done)
        begin
          rts_nxt = 1'b0;
          if (kind_msg_r)
          begin
            msg_clr = 1'b1;
            ev[IRQ_SENT] = 1'b1;
            st_nxt = ST_PICK;
          end
          else
          begin
            tmo_start = 1'b1;
            st_nxt = ST_WAIT;
          end
        end
      ST_WAIT:
        if (rx.eot)
        begin
          active_nxt[cur_r] = 1'b1;
          adv = 1'b1;
        end
        else if (rx.user_message_command)
        begin
          active_nxt[cur_r] = 1'b1;
          ev[IRQ_DATA] = 1'b1;
          if (ctrl_r[CTRL_MULTI])
          begin
            tries_nxt = 4'h0;
            rts_start = 1'b1;
            st_nxt = ST_RTSON;
          end
          else
            adv = 1'b1;
        end
        else if (tmo_done)
        begin
          if (tries_r < ctrl_r[CTRL_RETRY_LO +: 4])
          begin
            tries_nxt = tries_r + 4'h1;
            rts_start = 1'b1;
            st_nxt = ST_RTSON;
          end
          else
          begin
            active_nxt[cur_r] = 1'b0;
            ev[IRQ_NOANS] = 1'b1;
            adv = 1'b1;
          end
        end
      default: st_nxt = ST_IDLE;
    endcase
    if (adv)
    begin
      st_nxt = ST_PICK;
      if (from_prio_r)
      begin
        pidx_nxt = (IW+1)'(pidx_r) + 1'b1 >= plen_r ? '0 : pidx_r + 1'b1;
        prio_turn_nxt = 1'b0;
      end
      else
      begin
        nidx_nxt = (IW+1)'(nidx_r) + 1'b1 >= nlen_r ? '0 : nidx_r + 1'b1;
        ev[IRQ_WRAP] = (IW+1)'(nidx_r) + 1'b1 >= nlen_r;
        prio_turn_nxt = plen_r != '0;
      end
    end
  end

  always_ff @(posedge mclk_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      st_r <= ST_IDLE;
      cur_r <= 8'h00;
      nidx_r <= '0;
      pidx_r <= '0;
      prio_turn_r <= 1'b0;
      from_prio_r <= 1'b0;
      kind_msg_r <= 1'b0;
      tries_r <= 4'h0;
      bidx_r <= 3'h0;
      tx_byte_out <= 8'h00;
      tx_valid_out <= 1'b0;
      rts_out <= 1'b0;
      active_r <= '0;
      rx_data_out <= 8'h00;
      rx_data_valid_out <= 1'b0;
    end
    else
    begin
      st_r <= st_nxt;
      cur_r <= cur_nxt;
      nidx_r <= nidx_nxt;
      pidx_r <= pidx_nxt;
      prio_turn_r <= prio_turn_nxt;
      from_prio_r <= from_prio_nxt;
      kind_msg_r <= kind_msg_nxt;
      tries_r <= tries_nxt;
      bidx_r <= bidx_nxt;
      tx_byte_out <= tx_byte_nxt;
      tx_valid_out <= tx_valid_nxt;
      rts_out <= rts_nxt;
      active_r <= active_nxt;
      rx_data_out <= rx.dat_v ? rx.dat : rx_data_out;
      rx_data_valid_out <= rx.dat_v;
    end
  end

  hdp_timer #(.W(16)) u_rts_tmr (
    .mclk_in(mclk_in),
    .reset_in(reset_in),
    .tick_in(tick_r),
    .start_in(rts_start),
    .load_in(rts_load),
    .done_out(rts_done)
  );

  hdp_timer #(.W(16)) u_tmo_tmr (
    .mclk_in(mclk_in),
    .reset_in(reset_in),
    .tick_in(tick_r),
    .start_in(tmo_start),
    .load_in(tmo_r),
    .done_out(tmo_done)
  );

  // Replies are decoded only while waiting, whichever slave sends them
  hdp_rx_decode u_rx (
    .mclk_in(mclk_in),
    .reset_in(reset_in),
    .en_in(st_r == ST_WAIT),
    .byte_in(rx_byte_in),
    .valid_in(rx_valid_in),
    .ev_out(rx)
  );

  assign reg_rdata_out = rdata_r;
  assign irq_out = irq_r;
  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  sequence s_timeout_end;
    st_r == ST_WAIT && !rx.eot && !rx.user_message_command && tmo_done;
  endsequence

  a_tx_under_rts: assert property (tx_valid_out |-> rts_out)
    else $error("byte offered without RTS");
  a_poll_addr: assert property ((st_r == ST_SEND && !kind_msg_r && bidx_r == 3'h2)
    |-> tx_byte_out == cur_r)
    else $error("poll lacks slave address");
  a_wait_ends: assert property ((st_r == ST_WAIT && tmo_done) |=> st_r != ST_WAIT)
    else $error("wait outlived timeout");
  a_retry_resend: assert property ((s_timeout_end and tries_r < ctrl_r[7:4])
    |=> st_r == ST_RTSON && $stable(cur_r))
    else $error("unanswered poll not resent");
  a_go_inactive: assert property ((s_timeout_end and tries_r >= ctrl_r[7:4] and cur_r != 8'hff)
    |=> !active_r[$past(cur_r)] ##0 st_r == ST_PICK)
    else $error("slave not marked inactive");
  a_eot_active: assert property ((st_r == ST_WAIT && rx.eot && cur_r != 8'hff)
    |=> active_r[$past(cur_r)] && st_r == ST_PICK)
    else $error("reply did not set node bit");
  a_single_adv: assert property ((st_r == ST_WAIT && !rx.eot && rx.user_message_command && !ctrl_r[1])
    |=> st_r == ST_PICK)
    else $error("single mode did not advance");
  a_multi_repoll: assert property ((st_r == ST_WAIT && !rx.eot && rx.user_message_command && ctrl_r[1])
    |=> st_r == ST_RTSON && $stable(cur_r))
    else $error("multiple mode did not repoll");
  a_msg_first: assert property ((st_r == ST_PICK && msg_pend_r && ctrl_r[0])
    |=> kind_msg_r && cur_r == $past(msg_dest_r))
    else $error("queued message skipped");
  a_auto_poll: assert property ((st_r == ST_IDLE && ctrl_r[0] && nlen_r != '0 && !reg_wr_in)
    |=> ##1 st_r == ST_RTSON)
    else $error("poll not started");
  a_list_wrap: assert property ((adv && !from_prio_r && (IW+1)'(nidx_r) + 1'b1 >= nlen_r)
    |=> nidx_r == '0)
    else $error("list did not wrap");
  a_prio_turn: assert property ((adv && !from_prio_r && plen_r != '0) |=> prio_turn_r)
    else $error("priority entry not interleaved");
endmodule // hdp_poll_master

// >>> include/hdp_pkg.sv
// Shared constants and types of the half-duplex poll master
package hdp_pkg;
  // ----------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_TMO = 8'h04;
  localparam logic [7:0] REG_RTS_PRE = 8'h08;
  localparam logic [7:0] REG_RTS_POST = 8'h0c;
  localparam logic [7:0] REG_LEN = 8'h10;
  localparam logic [7:0] REG_LIST_WR = 8'h14;
  localparam logic [7:0] REG_MSG = 8'h18;
  localparam logic [7:0] REG_NODE = 8'h1c;
  localparam logic [7:0] REG_IRQ_STAT = 8'h20;
  localparam logic [7:0] REG_IRQ_MASK = 8'h24;
  localparam logic [7:0] REG_STATUS = 8'h28;
  localparam logic [7:0] REG_RXDATA = 8'h2c;
  // ----------------------------------------------------------------
  // Fields and reset values
  // ----------------------------------------------------------------
  localparam int CTRL_EN = 0;
  localparam int CTRL_MULTI = 1;
  localparam int CTRL_RETRY_LO = 4;
  localparam int LEN_PRIO_LO = 8;
  localparam int LIST_IDX_LO = 8;
  localparam int LIST_PRIO = 12;
  localparam int MSG_DATA_LO = 8;
  localparam logic [7:0] CTRL_RST = 8'h30;
  localparam logic [15:0] TMO_RST = 16'h03e8;
  localparam logic [15:0] RTS_PRE_RST = 16'h000a;
  localparam logic [15:0] RTS_POST_RST = 16'h000a;
  localparam logic [7:0] ADDR_BCAST = 8'hff;
  localparam int IRQ_NOANS = 0;
  localparam int IRQ_DATA = 1;
  localparam int IRQ_SENT = 2;
  localparam int IRQ_WRAP = 3;
  // ----------------------------------------------------------------
  // Link control bytes
  // ----------------------------------------------------------------
  localparam logic [7:0] B_DLE = 8'h10;
  localparam logic [7:0] B_STX = 8'h02;
  localparam logic [7:0] B_ETX = 8'h03;
  localparam logic [7:0] B_EOT = 8'h04;
  localparam logic [7:0] B_ENQ = 8'h05;
  // ----------------------------------------------------------------
  // Timing: timers count in ticks of 1 us
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_PS = 8000;
  localparam int TICK_NS = 1000;
  localparam int TICK_CYC = (TICK_NS * 1000) / CLK_PERIOD_PS;
  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [5:0] {
    ST_IDLE = 6'h01,
    ST_PICK = 6'h02,
    ST_RTSON = 6'h04,
    ST_SEND = 6'h08,
    ST_RTSOFF = 6'h10,
    ST_WAIT = 6'h20
  } hdp_state_t;
  typedef struct packed {
    logic eot;
    logic user_message_command;
    logic dat_v;
    logic [7:0] dat;
  } hdp_rx_ev_t;
endpackage

// >>> hdl/hdp_timer.sv
// Tick-driven one-shot delay timer
`timescale 1ns/1ps
module hdp_timer
  import hdp_pkg::*;
#(
  parameter int W = 16
)(
  input wire logic mclk_in,
  input wire logic reset_in,
  input wire logic tick_in,
  input wire logic start_in,
  input wire logic [W-1:0] load_in,
  output logic done_out
);
  logic [W-1:0] cnt_r, cnt_nxt;
  logic run_r, run_nxt;
  logic done_r, done_nxt;

  always_comb
  begin
    cnt_nxt = cnt_r;
    run_nxt = run_r;
    done_nxt = 1'b0;
    if (start_in)
    begin
      cnt_nxt = load_in;
      run_nxt = 1'b1;
    end
    else if (run_r && cnt_r == '0)
    begin
      run_nxt = 1'b0;
      done_nxt = 1'b1;
    end
    else if (run_r && tick_in)
      cnt_nxt = cnt_r - 1'b1;
  end

  always_ff @(posedge mclk_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      cnt_r <= '0;
      run_r <= 1'b0;
      done_r <= 1'b0;
    end
    else
    begin
      cnt_r <= cnt_nxt;
      run_r <= run_nxt;
      done_r <= done_nxt;
    end
  end

  assign done_out = done_r;
endmodule // hdp_timer

// >>> hdl/hdp_rx_decode.sv
// Reply parser: end-of-transmission and framed data packets
`timescale 1ns/1ps
module hdp_rx_decode
  import hdp_pkg::*;
(
  input wire logic mclk_in,
  input wire logic reset_in,
  input wire logic en_in,
  input wire logic [7:0] byte_in,
  input wire logic valid_in,
  output hdp_rx_ev_t ev_out
);
  // 0 idle, 1 after DLE, 2 body, 3 body after DLE
  logic [1:0] ps_r, ps_nxt;
  hdp_rx_ev_t ev_r, ev_nxt;

  always_comb
  begin
    ps_nxt = ps_r;
    ev_nxt = '0;
    if (!en_in)
      ps_nxt = 2'h0;
    else if (valid_in)
    begin
      case (ps_r)
        2'h0: ps_nxt = (byte_in == B_DLE) ? 2'h1 : 2'h0;
        2'h1:
        begin
          ev_nxt.eot = (byte_in == B_EOT);
          ps_nxt = (byte_in == B_STX) ? 2'h2 : 2'h0;
        end
        2'h2:
        begin
          ps_nxt = (byte_in == B_DLE) ? 2'h3 : 2'h2;
          ev_nxt.dat_v = (byte_in != B_DLE);
          ev_nxt.dat = byte_in;
        end
        default:
        begin
          ev_nxt.user_message_command = (byte_in == B_ETX);
          ev_nxt.dat_v = (byte_in == B_DLE);
          ev_nxt.dat = byte_in;
          ps_nxt = (byte_in == B_DLE) ? 2'h2 : 2'h0;
        end
      endcase
    end
  end

  always_ff @(posedge mclk_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      ps_r <= 2'h0;
      ev_r <= '0;
    end
    else
    begin
      ps_r <= ps_nxt;
      ev_r <= ev_nxt;
    end
  end

  assign ev_out = ev_r;

  a_eot_two_byte: assert property (@(posedge mclk_in) disable iff (reset_in)
    (en_in && valid_in && ps_r == 2'h1 && byte_in == B_EOT) |=> ev_r.eot)
    else $error("two-byte reply not decoded");
endmodule // hdp_rx_decode

// >>> testbench/hdp_slave_model.sv
// Slave station model on the far side of the half-duplex link
`timescale 1ns/1ps
module hdp_slave_model
  import hdp_pkg::*;
(
  input wire logic mclk_in,
  input wire logic [7:0] tx_byte_in,
  input wire logic tx_valid_in,
  output logic tx_ready_out,
  input wire logic rts_in,
  output logic [7:0] rx_byte_out,
  output logic rx_valid_out
);
  logic [7:0] h0, h1, addr;
  logic [1:0] data_n;
  logic due;
  int gap;
  logic [7:0] q[$];
  initial
  begin
    tx_ready_out = 1'b0;
    rx_byte_out = 8'h00;
    rx_valid_out = 1'b0;
    data_n = 2'h3;
    due = 1'b0;
    gap = 0;
  end
  always @(posedge mclk_in)
  begin
    tx_ready_out <= ~tx_ready_out;
    rx_valid_out <= 1'b0;
    rx_byte_out <= ~rx_byte_out;
    if (tx_valid_in && tx_ready_out)
    begin
      h1 <= h0;
      h0 <= tx_byte_in;
      if (h1 == B_DLE && h0 == B_ENQ)
      begin
        addr <= tx_byte_in;
        due <= 1'b1;
      end
    end
    if (due && !rts_in)
    begin
      due <= 1'b0;
      gap <= 8;
      // Station 33 never answers; only the addressed station replies
      if (addr == 8'h12 && data_n != 2'h0)
      begin
        q = '{B_DLE, B_STX, 8'ha5, B_DLE, B_ETX};
        data_n <= data_n - 2'h1;
      end
      else if (addr != 8'h33)
        q = '{B_DLE, B_EOT};
    end
    else if (gap > 0)
      gap <= gap - 1;
    else if (q.size() > 0)
    begin
      rx_byte_out <= q.pop_front();
      rx_valid_out <= 1'b1;
      gap <= 2;
    end
  end
endmodule // hdp_slave_model

// >>> testbench/test_half_duplex_poll_master.sv
// Self-checking bench of the half-duplex poll master
`timescale 1ns/1ps
module test_half_duplex_poll_master;
  import hdp_pkg::*;
  logic mclk_in = 1'b0;
  logic reset_in = 1'b1;
  logic [7:0] reg_addr_in = 8'h00;
  logic [31:0] reg_wdata_in = 32'h0;
  logic reg_wr_in = 1'b0;
  logic reg_rd_in = 1'b0;
  logic [31:0] reg_rdata_out;
  logic irq_out, tx_valid_out, tx_ready_in, rx_valid_in, rts_out, rx_data_valid_out;
  logic [7:0] tx_byte_out, rx_byte_in, rx_data_out, h0, h1;
  logic [7:0] pay = 8'h00;
  logic [7:0] polls[$];
  logic [7:0] txq[$];
  logic [39:0] rows [0:7];
  logic [7:0] exp_polls [0:7];
  int n_fail = 0;
  int cmp_count = 0;
  int k;
  always #4 mclk_in = ~mclk_in;
  hdp_poll_master #(.LIST_N(16)) dut_u (
    .mclk_in(mclk_in), .reset_in(reset_in), .reg_addr_in(reg_addr_in),
    .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
    .reg_rdata_out(reg_rdata_out), .irq_out(irq_out), .tx_byte_out(tx_byte_out),
    .tx_valid_out(tx_valid_out), .tx_ready_in(tx_ready_in), .rx_byte_in(rx_byte_in),
    .rx_valid_in(rx_valid_in), .rts_out(rts_out), .rx_data_out(rx_data_out),
    .rx_data_valid_out(rx_data_valid_out));
  hdp_slave_model slave_u (
    .mclk_in(mclk_in), .tx_byte_in(tx_byte_out), .tx_valid_in(tx_valid_out),
    .tx_ready_out(tx_ready_in), .rts_in(rts_out), .rx_byte_out(rx_byte_in),
    .rx_valid_out(rx_valid_in));
  // ----------------------------------------------------------------
  // Link monitor
  // ----------------------------------------------------------------
  always @(posedge mclk_in)
  begin
    if (rx_data_valid_out)
      pay <= rx_data_out;
    if (tx_valid_out && tx_ready_in)
    begin
      txq.push_back(tx_byte_out);
      h1 <= h0;
      h0 <= tx_byte_out;
      if (h1 == B_DLE && h0 == B_ENQ)
        polls.push_back(tx_byte_out);
    end
  end
  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic give_verdict;
    $display("Comparisons %0d, mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      n_fail++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk_in);
    reg_addr_in <= a;
    reg_wdata_in <= d;
    reg_wr_in <= 1'b1;
    @(posedge mclk_in);
    reg_wr_in <= 1'b0;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    @(posedge mclk_in);
    reg_addr_in <= a;
    reg_rd_in <= 1'b1;
    @(posedge mclk_in);
    reg_rd_in <= 1'b0;
    @(negedge mclk_in);
    chk(reg_rdata_out, exp);
  endtask
  function automatic bit msg_seen();
    for (int i = 0; i + 5 < txq.size(); i++)
      if (txq[i] == B_DLE && txq[i+1] == B_STX && txq[i+2] == 8'h21 &&
          txq[i+3] == 8'h5a && txq[i+4] == B_DLE && txq[i+5] == B_ETX)
        return 1'b1;
    return 1'b0;
  endfunction
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    rows = '{{REG_CTRL, 24'h0, CTRL_RST}, {REG_TMO, 16'h0, TMO_RST},
      {REG_RTS_PRE, 16'h0, RTS_PRE_RST}, {REG_RTS_POST, 16'h0, RTS_POST_RST},
      {REG_IRQ_STAT, 32'h0}, {REG_MSG, 32'h0}, {REG_STATUS, 32'h100}, {8'h30, 32'h0}};
    exp_polls = '{8'h12, 8'h40, 8'h33, 8'h33, 8'h40, 8'h21, 8'h40, 8'h12};
    repeat (8) @(posedge mclk_in);
    chk({irq_out, tx_valid_out, rts_out}, 32'h0);
    reset_in <= 1'b0;
    for (k = 0; k < 8; k++)
      rdc(rows[k][39:32], rows[k][31:0]);
    wr(REG_TMO, 32'h3);
    wr(REG_RTS_PRE, 32'h1);
    wr(REG_RTS_POST, 32'h1);
    wr(REG_LIST_WR, 32'h0012);
    wr(REG_LIST_WR, 32'h0133);
    wr(REG_LIST_WR, 32'h0221);
    wr(REG_LIST_WR, 32'h02ff);
    wr(REG_LIST_WR, 32'h1040);
    wr(REG_LEN, 32'h0103);
    wr(REG_IRQ_MASK, 32'hf);
    wr(REG_CTRL, 32'h11);
    for (k = 0; k < 30000 && polls.size() < 8; k++)
      @(posedge mclk_in);
    if (polls.size() < 8)
    begin
      n_fail++;
      give_verdict();
    end
    for (k = 0; k < 8; k++)
      chk(polls[k], exp_polls[k]);
    chk(pay, 8'ha5);
    wr(REG_NODE, 32'h33);
    rdc(REG_NODE, 32'h0);
    wr(REG_NODE, 32'h12);
    rdc(REG_NODE, 32'h1);
    wr(REG_MSG, 32'h5a21);
    for (k = 0; k < 8000 && !msg_seen(); k++)
      @(posedge mclk_in);
    chk(msg_seen(), 32'h1);
    repeat (300) @(posedge mclk_in);
    rdc(REG_MSG, 32'h0);
    rdc(REG_IRQ_STAT, 32'hf);
    chk(irq_out, 32'h1);
    wr(REG_IRQ_MASK, 32'h0);
    repeat (2) @(negedge mclk_in);
    chk(irq_out, 32'h0);
    wr(REG_IRQ_MASK, 32'h4);
    wr(REG_IRQ_STAT, 32'h4);
    repeat (2) @(negedge mclk_in);
    chk(irq_out, 32'h0);
    rdc(REG_RXDATA, 32'ha5);
    wr(REG_CTRL, 32'h13);
    for (k = 0; k < 30000 && polls.size() < 17; k++)
      @(posedge mclk_in);
    if (polls.size() < 17)
    begin
      n_fail++;
      give_verdict();
    end
    chk({polls[13], polls[14], polls[15], polls[16]}, 32'h4012_1240);
    give_verdict();
  end
endmodule // test_half_duplex_poll_master
